// file: core/pll_profile_map.vh
`ifndef PLL_PROFILE_MAP_VH
`define PLL_PROFILE_MAP_VH

`define OFS_SPREAD_HI 8'h10
`define OFS_SPREAD_MID 8'h11
`define OFS_SPREAD_LO 8'h12
`define OFS_FREQ_PROFILE 8'h13
`define OFS_BYPASS_MUX 8'h14
`define OFS_STATE_SELECT 8'h15
`define OFS_SPREAD_MODE 8'h16
`define OFS_NV_CTRL 8'h06
`define OFS_NV_STATUS 8'h07
`define OFS_MAP_TOP 8'h40

`define RST_SPREAD 8'h00
`define RST_FREQ_PROFILE 8'h00
`define RST_BYPASS_MUX 8'hed
`define RST_STATE_SELECT 8'h02
`define RST_SPREAD_MODE 8'h00

`define BIT_BYPASS 7
`define BIT_OUT2_SRC 6
`define BIT_OUT3_SRC_HI 5
`define BIT_OUT3_SRC_LO 4
`define BIT_ST1_HI 3
`define BIT_ST1_LO 2
`define BIT_ST0_HI 1
`define BIT_ST0_LO 0
`define BIT_SPREAD_CENTER 7
`define BIT_NV_TRIGGER 0
`define BIT_NV_LOCK 1
`define BIT_NV_BUSY 0

`define OUT3_RESERVED 2'h3
`define OUT_ST_PWRDN 2'h0

`define NV_WRITE_TIME_US 10
`define CLK_MHZ 250

`endif

// file: core/pll_profile_select_config.v
// Functional notes
// [RL1] Eight settings, chosen by three select pins
// [RL2] Down-spread amount codes 000 off..111 2.0%
// [RL3] Center-spread codes off then plus/minus amounts
// [RL4] Amount fields packed MSB-first over 10h-12h
// [RL5] Frequency bit picks VCO profile zero/one
// [RL6] Bypass bit 1 bypasses, powers PLL down
// [RL7] Out2 source: 0 divider one, 1 two
// [RL8] Out3 source 00/01/10, 11 reserved
// [RL9] Output state definitions, defaults 11 and 01
// [RL10] Write cycle starts only on trigger rise
// [RL11] Host writes trigger last, clears it after
// [RL12] Busy status bit readable for polling
// [RL13] Lock bit blocks every non-volatile write
// [RL14] Host avoids writes above map top
// [RL15] Bytes move MSB first both directions
// [RL16] Spread mode bit: 0 down, 1 center
// [RL17] Per-setting state select bit picks definition
// [RL18] Host sends no writes during busy
// [RL19] Select change switches all fields together
`timescale 1ns/1ns
`default_nettype none
`include "pll_profile_map.vh"

module pll_profile_select_config #(
    parameter NV_WRITE_CYCLES = `NV_WRITE_TIME_US * `CLK_MHZ
) (
    input wire ref_clk,
    input wire rst_n,
    input wire ctrl_sel_pin0,
    input wire ctrl_sel_pin1,
    input wire ctrl_sel_pin2,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg [2:0] spread_amount_setting,
    output reg spread_center_sel,
    output reg freq_profile_bit,
    output reg pll_bypass_sel,
    output reg pll_power_down,
    output reg out2_source_sel,
    output reg [1:0] out3_source_sel,
    output reg [1:0] out23_state,
    output reg [2:0] active_index,
    output reg nv_write_start,
    output reg nv_write_in_progress
);

    localparam NV_IDLE = 1'b0;
    localparam NV_BUSY = 1'b1;
    localparam [31:0] NV_LOAD = NV_WRITE_CYCLES - 1;

    wire [2:0] sel_raw;
    wire [2:0] sel_q;
    reg [7:0] spread_hi_q;
    reg [7:0] spread_hi_d;
    reg [7:0] spread_mid_q;
    reg [7:0] spread_mid_d;
    reg [7:0] spread_lo_q;
    reg [7:0] spread_lo_d;
    reg [7:0] freq_q;
    reg [7:0] freq_d;
    reg [7:0] mux_q;
    reg [7:0] mux_d;
    reg [7:0] state_sel_q;
    reg [7:0] state_sel_d;
    reg [7:0] mode_q;
    reg [7:0] mode_d;
    reg trig_q;
    reg trig_d;
    reg trig_prev_q;
    reg nv_lock_q;
    reg nv_lock_d;
    reg nv_state_q;
    reg nv_state_d;
    reg [31:0] nv_cnt_q;
    reg [31:0] nv_cnt_d;
    reg start_d;
    reg busy_d;
    reg [7:0] rdata_d;
    reg [2:0] amount_d;
    reg center_d;
    reg freq_bit_d;
    reg bypass_d;
    reg power_down_d;
    reg out2_src_d;
    reg [1:0] out3_src_d;
    reg [1:0] out23_state_d;
    wire [23:0] spread_all;
    wire [2:0] amount;
    wire [1:0] st_def;
    wire wr_ok;
    wire [1:0] out3_src_wr;
    wire [1:0] out3_keep;
    wire nv_rise;

    assign sel_raw = {ctrl_sel_pin2, ctrl_sel_pin1, ctrl_sel_pin0};
    // Setting seven sits in the top bits of 10h
    assign spread_all = {spread_hi_q, spread_mid_q, spread_lo_q}; // see [RL4]
    assign amount = spread_all[sel_q * 3 +: 3]; // see [RL1]
    assign st_def = state_sel_q[sel_q] ? mux_q[`BIT_ST1_HI:`BIT_ST1_LO]
                                       : mux_q[`BIT_ST0_HI:`BIT_ST0_LO]; // see [RL17]
    // Writes ignored while busy and above the map; protects the snapshot
    assign wr_ok = reg_wr && !nv_write_in_progress && reg_addr < `OFS_MAP_TOP; // see [RL18]
    // Reserved source code keeps the old value rather than a meaningless route
    assign out3_src_wr = reg_wdata[`BIT_OUT3_SRC_HI:`BIT_OUT3_SRC_LO];
    assign out3_keep = (out3_src_wr == `OUT3_RESERVED) ? mux_q[5:4] : out3_src_wr; // see [RL8]
    // Rising edge only; a held-high trigger never restarts
    assign nv_rise = trig_q && !trig_prev_q; // see [RL10]

    // Pins cross in; accept once stages two and three agree
    pin_filter #(
        .WIDTH(3)
    ) sel_filter_u (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_in(sel_raw),
        .level_out(sel_q) // see [RL1]
    );

    always @* begin
        spread_hi_d = spread_hi_q;
        spread_mid_d = spread_mid_q;
        spread_lo_d = spread_lo_q;
        freq_d = freq_q;
        mux_d = mux_q;
        state_sel_d = state_sel_q;
        mode_d = mode_q;
        trig_d = trig_q;
        nv_lock_d = nv_lock_q;
        if (wr_ok) begin
            case (reg_addr)
                `OFS_SPREAD_HI: begin
                    spread_hi_d = reg_wdata;
                end
                `OFS_SPREAD_MID: begin
                    spread_mid_d = reg_wdata;
                end
                `OFS_SPREAD_LO: begin
                    spread_lo_d = reg_wdata;
                end
                `OFS_FREQ_PROFILE: begin
                    freq_d = reg_wdata;
                end
                `OFS_BYPASS_MUX: begin
                    mux_d = {reg_wdata[7:6], out3_keep, reg_wdata[3:0]};
                end
                `OFS_STATE_SELECT: begin
                    state_sel_d = reg_wdata;
                end
                `OFS_SPREAD_MODE: begin
                    mode_d = {reg_wdata[7], 7'h00};
                end
                `OFS_NV_CTRL: begin
                    trig_d = reg_wdata[`BIT_NV_TRIGGER];
                    nv_lock_d = reg_wdata[`BIT_NV_LOCK];
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            spread_hi_q <= `RST_SPREAD;
            spread_mid_q <= `RST_SPREAD;
            spread_lo_q <= `RST_SPREAD;
            freq_q <= `RST_FREQ_PROFILE;
            mux_q <= `RST_BYPASS_MUX;
            state_sel_q <= `RST_STATE_SELECT;
            mode_q <= `RST_SPREAD_MODE;
            trig_q <= 1'b0;
            nv_lock_q <= 1'b0;
        end else begin
            spread_hi_q <= spread_hi_d;
            spread_mid_q <= spread_mid_d;
            spread_lo_q <= spread_lo_d;
            freq_q <= freq_d;
            mux_q <= mux_d;
            state_sel_q <= state_sel_d;
            mode_q <= mode_d;
            trig_q <= trig_d;
            nv_lock_q <= nv_lock_d;
        end
    end

    always @* begin
        nv_state_d = nv_state_q;
        nv_cnt_d = nv_cnt_q;
        start_d = 1'b0;
        case (nv_state_q)
            NV_IDLE: begin
                // Lock only blocks the start; the trigger bit itself still stores
                if (nv_rise && !nv_lock_q) begin // see [RL13]
                    nv_state_d = NV_BUSY;
                    nv_cnt_d = NV_LOAD;
                    start_d = 1'b1; // see [RL10]
                end
            end
            NV_BUSY: begin
                if (nv_cnt_q == 32'h0) begin
                    nv_state_d = NV_IDLE;
                end else begin
                    nv_cnt_d = nv_cnt_q - 32'h1;
                end
            end
            default: begin
                nv_state_d = NV_IDLE;
            end
        endcase
        busy_d = nv_state_d == NV_BUSY; // see [RL12]
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            trig_prev_q <= 1'b0;
            nv_state_q <= NV_IDLE;
            nv_cnt_q <= 32'h0;
            nv_write_start <= 1'b0;
            nv_write_in_progress <= 1'b0;
        end else begin
            trig_prev_q <= trig_q;
            nv_state_q <= nv_state_d;
            nv_cnt_q <= nv_cnt_d;
            nv_write_start <= start_d;
            nv_write_in_progress <= busy_d; // see [RL12]
        end
    end

    // All per-setting fields follow one index in the same cycle
    always @* begin
        amount_d = amount; // see [RL2]
        center_d = mode_q[`BIT_SPREAD_CENTER]; // see [RL16] see [RL3]
        freq_bit_d = freq_q[sel_q]; // see [RL5]
        bypass_d = mux_q[`BIT_BYPASS]; // see [RL6]
        out2_src_d = mux_q[`BIT_OUT2_SRC]; // see [RL7]
        out3_src_d = mux_q[`BIT_OUT3_SRC_HI:`BIT_OUT3_SRC_LO]; // see [RL8]
        out23_state_d = st_def; // see [RL9]
        power_down_d = bypass_d || out23_state_d == `OUT_ST_PWRDN; // see [RL9]
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            spread_amount_setting <= 3'h0;
            spread_center_sel <= 1'b0;
            freq_profile_bit <= 1'b0;
            pll_bypass_sel <= 1'b1;
            pll_power_down <= 1'b1;
            out2_source_sel <= 1'b1;
            out3_source_sel <= 2'h2;
            out23_state <= 2'h1;
            active_index <= 3'h0;
        end else begin
            active_index <= sel_q; // see [RL19]
            spread_amount_setting <= amount_d;
            spread_center_sel <= center_d;
            freq_profile_bit <= freq_bit_d;
            pll_bypass_sel <= bypass_d;
            pll_power_down <= power_down_d;
            out2_source_sel <= out2_src_d;
            out3_source_sel <= out3_src_d;
            out23_state <= out23_state_d;
        end
    end

    // Byte interface is parallel, so bit order is the serialiser's concern
    always @* begin
        rdata_d = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                `OFS_SPREAD_HI: rdata_d = spread_hi_q; // see [RL15]
                `OFS_SPREAD_MID: rdata_d = spread_mid_q;
                `OFS_SPREAD_LO: rdata_d = spread_lo_q;
                `OFS_FREQ_PROFILE: rdata_d = freq_q;
                `OFS_BYPASS_MUX: rdata_d = mux_q;
                `OFS_STATE_SELECT: rdata_d = state_sel_q;
                `OFS_SPREAD_MODE: rdata_d = mode_q;
                `OFS_NV_CTRL: rdata_d = {6'h00, nv_lock_q, trig_q};
                `OFS_NV_STATUS: rdata_d = {7'h00, nv_write_in_progress}; // see [RL12]
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

endmodule

module pin_filter #(
    parameter WIDTH = 3
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] level_out
);

    reg [WIDTH-1:0] stage1_q;
    reg [WIDTH-1:0] stage2_q;
    reg [WIDTH-1:0] stage3_q;

    // Whole word accepted at once, so pin skew shorter than one clock never picks a stray setting
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            stage1_q <= {WIDTH{1'b0}};
            stage2_q <= {WIDTH{1'b0}};
            stage3_q <= {WIDTH{1'b0}};
            level_out <= {WIDTH{1'b0}};
        end else begin
            stage1_q <= pin_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            if (stage2_q == stage3_q) begin
                level_out <= stage3_q;
            end
        end
    end

endmodule
`default_nettype wire

// file: verif/cfg_sva.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_sva #(parameter NV_WRITE_CYCLES = 8) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ctrl_sel_pin0,
    input wire logic ctrl_sel_pin1,
    input wire logic ctrl_sel_pin2,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic pll_bypass_sel,
    input wire logic pll_power_down,
    input wire logic [1:0] out3_source_sel,
    input wire logic [2:0] active_index,
    input wire logic nv_write_start,
    input wire logic nv_write_in_progress
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic trig_q;
    wire logic [2:0] sel = {ctrl_sel_pin2, ctrl_sel_pin1, ctrl_sel_pin0};
    wire logic nv_wr = reg_wr && reg_addr == 8'h06 && !nv_write_in_progress;
    wire logic mux_wr = reg_wr && reg_addr == 8'h14 && !nv_write_in_progress;
    // Last accepted trigger level, since only a rise may start a cycle
    always @(posedge ref_clk) trig_q <= !rst_n ? 1'b0 : nv_wr ? reg_wdata[0] : trig_q;
    sequence rise_wr;
        nv_wr && reg_wdata[1:0] == 2'b01 && !trig_q;
    endsequence
    sequence start_pulse;
        nv_write_start && nv_write_in_progress ##1 !nv_write_start;
    endsequence
    trig_rise_a: assert property (rise_wr |-> ##2 start_pulse)
        else $error("no start after trigger rise");
    trig_held_a: assert property (nv_wr && (reg_wdata[1] || trig_q || !reg_wdata[0])
        |-> ##2 !nv_write_start) else $error("start without clean rise");
    busy_len_a: assert property (nv_write_start |-> nv_write_in_progress[*8]
        ##1 !nv_write_in_progress) else $error("busy length wrong");
    busy_cause_a: assert property ($rose(nv_write_in_progress) |-> nv_write_start)
        else $error("busy without start");
    bypass_pd_a: assert property (pll_bypass_sel |-> pll_power_down)
        else $error("bypass without power down");
    bypass_wr_a: assert property (mux_wr |-> ##2 pll_bypass_sel == $past(reg_wdata[7], 2))
        else $error("bypass bit not applied");
    out3_hold_a: assert property (mux_wr && reg_wdata[5:4] == 2'b11
        |-> ##2 $stable(out3_source_sel)) else $error("reserved source taken");
    status_rd_a: assert property (reg_rd && reg_addr == 8'h07
        |=> reg_rdata == {7'h00, $past(nv_write_in_progress)}) else $error("status read wrong");
    index_follow_a: assert property ($stable(sel)[*8] |-> active_index == sel)
        else $error("index not following pins");
endmodule
bind pll_profile_select_config cfg_sva #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk_u (.ref_clk,
    .rst_n, .ctrl_sel_pin0, .ctrl_sel_pin1, .ctrl_sel_pin2, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .pll_bypass_sel, .pll_power_down, .out3_source_sel, .active_index,
    .nv_write_start, .nv_write_in_progress);
`default_nettype wire

// file: verif/cfg_host.sv
`timescale 1ns/1ns
`default_nettype none
module cfg_host (
    input wire logic ref_clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic [2:0] sel
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata, sel} = '0;
    // Offsets stay below the map top; address inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge ref_clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) #1 {reg_rd, reg_addr} = {1'b1, a};
        @(posedge ref_clk) #1 {reg_rd, reg_addr} = {1'b0, ~a};
        d = reg_rdata;
    endtask
    // Pins are held long enough to pass the filter flops
    task automatic pick(input logic [2:0] k);
        @(posedge ref_clk) #1 sel = k;
        repeat (8) @(posedge ref_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr, reg_rd, spread_center_sel, freq_profile_bit, pll_bypass_sel, pll_power_down;
    logic out2_source_sel, nv_write_start, nv_write_in_progress;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
    logic [2:0] sel, spread_amount_setting, active_index;
    logic [1:0] out3_source_sel, out23_state;
    int error_cnt = 0, n_compared = 0, starts = 0, cycles = 0;
    logic [7:0] rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hed, 8'h02, 8'h00};
    logic [15:0] prog [7] = '{16'h10fa, 16'h11c6, 16'h1288, 16'h13aa, 16'h15cc, 16'h1680, 16'h141e};
    pll_profile_select_config #(.NV_WRITE_CYCLES(8)) dut_u (.*, .ctrl_sel_pin0(sel[0]),
        .ctrl_sel_pin1(sel[1]), .ctrl_sel_pin2(sel[2]));
    cfg_host host_u (.ref_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .sel);
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (nv_write_start === 1'b1) starts <= starts + 1;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, got);
        chk(got, e);
    endtask
    task automatic final_report;
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        foreach (rst_tab[i]) rchk(8'h10 + 8'(i), rst_tab[i]);
        chk({pll_bypass_sel, out2_source_sel, out3_source_sel, out23_state, pll_power_down,
            spread_center_sel}, 8'he6);
        rchk(8'h30, 8'h00);
        foreach (prog[i]) host_u.wr(prog[i][15:8], prog[i][7:0]);
        foreach (prog[i]) rchk(prog[i][15:8], prog[i][7:0]);
        for (int k = 7; k >= 0; k--) begin
            host_u.pick(3'(k));
            chk({2'b0, spread_amount_setting, active_index}, {2'b0, 3'(k), 3'(k)});
            chk({freq_profile_bit, spread_center_sel, out23_state, pll_power_down, out2_source_sel,
                out3_source_sel}, {k[0], 1'b1, k[1] ? 2'b11 : 2'b10, 4'b0001});
        end
        for (int j = 0; j < 4; j++) begin
            host_u.wr(8'h14, {2'b01, 2'(j), 4'hc});
            repeat (2) @(posedge ref_clk);
            #1;
            chk({3'b0, pll_power_down, out23_state, out3_source_sel},
                {4'b0001, 2'b00, j == 3 ? 2'b10 : 2'(j)});
        end
        host_u.wr(8'h14, 8'h1e);
        host_u.wr(8'h06, 8'h01);
        repeat (2) @(posedge ref_clk);
        rchk(8'h07, 8'h01);
        host_u.wr(8'h14, 8'h80);
        repeat (12) @(posedge ref_clk);
        rchk(8'h14, 8'h1e);
        rchk(8'h07, 8'h00);
        host_u.wr(8'h06, 8'h01);
        host_u.wr(8'h06, 8'h00);
        host_u.wr(8'h06, 8'h03);
        host_u.wr(8'h06, 8'h00);
        host_u.wr(8'h06, 8'h01);
        repeat (12) @(posedge ref_clk);
        host_u.wr(8'h06, 8'h00);
        chk(8'(starts), 8'h02);
        final_report();
    end
endmodule
`default_nettype wire
